// *** fjs_regs.vh ***
// Register offsets, field positions, reset values and constants of the frequency justifier.
`ifndef FJS_REGS_VH
`define FJS_REGS_VH
`define FJS_OFF_CTRL 8'h00
`define FJS_OFF_OPP 8'h04
`define FJS_OFF_NOM 8'h08
`define FJS_OFF_STEP 8'h0c
`define FJS_OFF_THR_HI 8'h10
`define FJS_OFF_THR_LO 8'h14
`define FJS_OFF_GAP 8'h18
`define FJS_OFF_STATUS 8'h1c
`define FJS_OFF_POS_CNT 8'h20
`define FJS_OFF_NEG_CNT 8'h24
`define FJS_CTRL_MODE 1:0
`define FJS_CTRL_OPP_ALL 2
`define FJS_CTRL_DITHER 3
`define FJS_CTRL_MON 4
`define FJS_MODE_ASYNC 2'h0
`define FJS_MODE_SLOT 2'h1
`define FJS_MODE_OCTET 2'h2
`define FJS_MODE_BIT 2'h3
`define FJS_RST_MODE 2'h0
`define FJS_RST_OPP 8'h00
`define FJS_RST_NOM 16'h0008
`define FJS_RST_STEP 8'h01
`define FJS_RST_THR_HI 16'h0100
`define FJS_RST_THR_LO 16'h0080
`define FJS_RST_GAP 8'h00
`define FJS_SLOT_BITS 16'h0040
`define FJS_FILL_MAX 16'hffff
`define FJS_OCTET_SHIFT 3
`define FJS_RESP_OKAY 2'h0
`define FJS_RESP_SLVERR 2'h2
`endif

// *** fjs_justifier.v ***
// Source-side frequency justifier for a channel adaptation, with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fjs_regs.vh"

// Behaviour
// - Slot mode justifies in 64 UI steps.
// - Octet mode justifies in 8 UI steps.
// - Bit mode justifies in 1 UI steps.
// - Async modes: only idle when no data.
// - Supervision marker counts as idle slot.
// - Slot opportunities: every slot or restricted.
// - Fast input: data replaces an idle slot.
// - Slow input: idle replaces a data slot.
// - Positive event flags positive justification.
// - Negative event flags negative justification.
// - Separate positive and negative counters.
// - Dither justifications are never counted.
// - Fill level tracks phase, drives decisions.
// - Octet frames carry used octet count.
// - Positive adds whole octets, at least one.
// - Negative removes whole octets, at least one.
// - Idle gap between frames keeps slot rate.
// - Frame opportunities: every frame or restricted.
// - Bit mode uses bit count, never idles.
// - Fast bit mode sends extra bits.
// - Slow bit mode sends fewer bits.
// - Idle marker is a non-data slot word.
module fjs_justifier #(
  parameter CNT_W = 32
) (
  input wire CLK_SYS,
  input wire NRST,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [63:0] CLI_DATA,
  input wire [6:0] CLI_BITS,
  input wire CLI_VALID,
  output wire CLI_READY,
  input wire SLOT_REQ,
  input wire PSM_REQ,
  output reg SLOT_VALID,
  output reg [63:0] SLOT_DATA,
  output reg SLOT_IDLE,
  output reg SLOT_PSM,
  output reg [15:0] FRAME_USED,
  output reg [7:0] FRAME_GAP,
  output reg POS_JUSTIFY_EVENT,
  output reg NEG_JUSTIFY_EVENT
);

  reg [1:0] mode;
  reg opp_all;
  reg dither_en;
  reg mon_en;
  reg [7:0] opp_period;
  reg [15:0] nom_units;
  reg [7:0] step;
  reg [15:0] thr_hi;
  reg [15:0] thr_lo;
  reg [7:0] gap_base;
  reg [15:0] fill;
  reg [CNT_W-1:0] pos_justify_count;
  reg [CNT_W-1:0] neg_justify_count;
  reg [7:0] opp_cnt;
  reg alt;
  reg [2:0] gap_res;
  reg [63:0] cli_word;

  reg aw_held;
  reg [7:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg bvalid;
  reg [1:0] bresp;
  reg rvalid;
  reg [31:0] rdata;
  reg [1:0] rresp;

  // Bus slave: address and data are held independently, so either may arrive first.
  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY = !w_held && !bvalid;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;

  wire wr_fire = aw_held && w_held && !bvalid;
  wire rd_fire = S_AXI_ARVALID && !rvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  wire [31:0] ctrl_word = {27'h0, mon_en, dither_en, opp_all, mode};
  wire [31:0] ctrl_new = merge(ctrl_word, w_data, w_strb);
  wire [31:0] opp_new = merge({24'h0, opp_period}, w_data, w_strb);
  wire [31:0] nom_new = merge({16'h0, nom_units}, w_data, w_strb);
  wire [31:0] step_new = merge({24'h0, step}, w_data, w_strb);
  wire [31:0] hi_new = merge({16'h0, thr_hi}, w_data, w_strb);
  wire [31:0] lo_new = merge({16'h0, thr_lo}, w_data, w_strb);
  wire [31:0] gap_new = merge({24'h0, gap_base}, w_data, w_strb);

  reg wr_ok;
  always @* begin
    case (aw_addr)
      `FJS_OFF_CTRL, `FJS_OFF_OPP, `FJS_OFF_NOM, `FJS_OFF_STEP,
      `FJS_OFF_THR_HI, `FJS_OFF_THR_LO, `FJS_OFF_GAP,
      `FJS_OFF_POS_CNT, `FJS_OFF_NEG_CNT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Phase tracking: fill level in bits of client data not yet sent.
  wire hi = fill > thr_hi;
  wire lo = fill < thr_lo;
  wire band = !hi && !lo;
  wire has_word = fill >= `FJS_SLOT_BITS;
  wire opp = opp_all || (opp_cnt == 8'h00);
  wire dith = opp && dither_en && band;

  reg send;
  reg idle;
  reg pos_j;
  reg neg_j;
  reg pos_x;
  reg neg_x;
  reg [15:0] used;
  reg [15:0] out_bits;
  always @* begin
    send = 1'b0;
    idle = 1'b0;
    pos_j = 1'b0;
    neg_j = 1'b0;
    pos_x = 1'b0;
    neg_x = 1'b0;
    used = nom_units;
    case (mode)
      `FJS_MODE_ASYNC: begin
        send = has_word;
        idle = !has_word;
      end
      `FJS_MODE_SLOT: begin
        // Opportunity slots alternate between a nominal idle and a nominal data slot,
        // so both directions of justification have room.
        if (opp && alt) begin
          send = has_word && (hi || dith);
          pos_j = send;
          pos_x = send && hi;
        end else if (opp && (lo || dith)) begin
          send = 1'b0;
          neg_j = 1'b1;
          neg_x = lo;
        end else begin
          send = has_word;
        end
        idle = !send;
      end
      default: begin
        send = 1'b1;
        if (opp && hi) begin
          used = nom_units + {8'h0, step};
          pos_j = 1'b1;
          pos_x = 1'b1;
        end else if (opp && lo) begin
          used = (nom_units > {8'h0, step}) ? nom_units - {8'h0, step} : 16'h0000;
          neg_j = 1'b1;
          neg_x = 1'b1;
        end else if (dith) begin
          // Balanced dither: alternate directions, never counted.
          used = alt ? nom_units + {8'h0, step} : nom_units - {8'h0, step};
          pos_j = alt;
          neg_j = !alt;
        end
      end
    endcase
    if (!mode[1])
      out_bits = send ? `FJS_SLOT_BITS : 16'h0000;
    else if (mode == `FJS_MODE_OCTET)
      out_bits = used << `FJS_OCTET_SHIFT;
    else
      out_bits = used;
  end

  // Octet mode: length change of a frame is absorbed by the idle gap after it.
  wire signed [18:0] gsum = $signed({16'h0, gap_res}) + $signed({3'h0, nom_units})
    - $signed({3'h0, used});
  wire signed [18:0] gap_s = $signed({11'h0, gap_base}) + (gsum >>> `FJS_OCTET_SHIFT);
  reg [7:0] gap_out;
  always @* begin
    if (mode != `FJS_MODE_OCTET)
      gap_out = 8'h00;
    else if (gap_s < 0)
      gap_out = 8'h00;
    else if (gap_s > 19'sd255)
      gap_out = 8'hff;
    else
      gap_out = gap_s[7:0];
  end

  // Fill update clips only at the bottom; an underflow means the client ran dry and is clipped at zero.
  assign CLI_READY = fill <= (`FJS_FILL_MAX - `FJS_SLOT_BITS);
  wire take = CLI_VALID && CLI_READY;
  wire signed [17:0] fsum = $signed({2'h0, fill}) + $signed({11'h0, take ? CLI_BITS : 7'h00})
    - $signed({2'h0, SLOT_REQ ? out_bits : 16'h0000});
  wire [15:0] next_fill = (fsum < 0) ? 16'h0000 : fsum[15:0];

  wire count_on = mon_en && (mode != `FJS_MODE_ASYNC);
  wire pos_cnt_inc = SLOT_REQ && pos_x && count_on;
  wire neg_cnt_inc = SLOT_REQ && neg_x && count_on;
  wire pos_clr = wr_fire && (aw_addr == `FJS_OFF_POS_CNT);
  wire neg_clr = wr_fire && (aw_addr == `FJS_OFF_NEG_CNT);

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      mode <= `FJS_RST_MODE;
      opp_all <= 1'b0;
      dither_en <= 1'b0;
      mon_en <= 1'b0;
      opp_period <= `FJS_RST_OPP;
      nom_units <= `FJS_RST_NOM;
      step <= `FJS_RST_STEP;
      thr_hi <= `FJS_RST_THR_HI;
      thr_lo <= `FJS_RST_THR_LO;
      gap_base <= `FJS_RST_GAP;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `FJS_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `FJS_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `FJS_RESP_OKAY : `FJS_RESP_SLVERR;
        case (aw_addr)
          `FJS_OFF_CTRL: begin
            mode <= ctrl_new[`FJS_CTRL_MODE];
            opp_all <= ctrl_new[`FJS_CTRL_OPP_ALL];
            dither_en <= ctrl_new[`FJS_CTRL_DITHER];
            mon_en <= ctrl_new[`FJS_CTRL_MON];
          end
          `FJS_OFF_OPP: opp_period <= opp_new[7:0];
          `FJS_OFF_NOM: nom_units <= nom_new[15:0];
          `FJS_OFF_STEP: step <= (step_new[7:0] == 8'h00) ? 8'h01 : step_new[7:0];
          `FJS_OFF_THR_HI: thr_hi <= hi_new[15:0];
          `FJS_OFF_THR_LO: thr_lo <= lo_new[15:0];
          `FJS_OFF_GAP: gap_base <= gap_new[7:0];
          default: begin
          end
        endcase
      end else if (bvalid && S_AXI_BREADY) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rresp <= `FJS_RESP_OKAY;
        case ({S_AXI_ARADDR[7:2], 2'h0})
          `FJS_OFF_CTRL: rdata <= ctrl_word;
          `FJS_OFF_OPP: rdata <= {24'h0, opp_period};
          `FJS_OFF_NOM: rdata <= {16'h0, nom_units};
          `FJS_OFF_STEP: rdata <= {24'h0, step};
          `FJS_OFF_THR_HI: rdata <= {16'h0, thr_hi};
          `FJS_OFF_THR_LO: rdata <= {16'h0, thr_lo};
          `FJS_OFF_GAP: rdata <= {24'h0, gap_base};
          `FJS_OFF_STATUS: rdata <= {13'h0, alt, lo, hi, fill};
          `FJS_OFF_POS_CNT: rdata <= pos_justify_count;
          `FJS_OFF_NEG_CNT: rdata <= neg_justify_count;
          default: begin
            rdata <= 32'h0;
            rresp <= `FJS_RESP_SLVERR;
          end
        endcase
      end else if (rvalid && S_AXI_RREADY) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Counters: a write clears, but an event in the same cycle still counts.
  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      pos_justify_count <= {CNT_W{1'b0}};
      neg_justify_count <= {CNT_W{1'b0}};
    end else begin
      if (pos_clr)
        pos_justify_count <= {{(CNT_W-1){1'b0}}, pos_cnt_inc};
      else if (pos_cnt_inc)
        pos_justify_count <= pos_justify_count + 1'b1;
      if (neg_clr)
        neg_justify_count <= {{(CNT_W-1){1'b0}}, neg_cnt_inc};
      else if (neg_cnt_inc)
        neg_justify_count <= neg_justify_count + 1'b1;
    end
  end

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      fill <= 16'h0000;
      cli_word <= 64'h0;
      opp_cnt <= 8'h00;
      alt <= 1'b0;
      gap_res <= 3'h0;
      SLOT_VALID <= 1'b0;
      SLOT_DATA <= 64'h0;
      SLOT_IDLE <= 1'b0;
      SLOT_PSM <= 1'b0;
      FRAME_USED <= 16'h0000;
      FRAME_GAP <= 8'h00;
      POS_JUSTIFY_EVENT <= 1'b0;
      NEG_JUSTIFY_EVENT <= 1'b0;
    end else begin
      fill <= next_fill;
      if (take)
        cli_word <= CLI_DATA;
      SLOT_VALID <= SLOT_REQ;
      POS_JUSTIFY_EVENT <= SLOT_REQ && pos_j;
      NEG_JUSTIFY_EVENT <= SLOT_REQ && neg_j;
      if (SLOT_REQ) begin
        opp_cnt <= (opp_cnt >= opp_period) ? 8'h00 : opp_cnt + 8'h01;
        if (opp && mode != `FJS_MODE_ASYNC)
          alt <= !alt;
        SLOT_DATA <= send ? cli_word : 64'h0;
        SLOT_IDLE <= idle && !mode[1];
        SLOT_PSM <= idle && !mode[1] && PSM_REQ;
        FRAME_USED <= mode[1] ? used : 16'h0000;
        FRAME_GAP <= gap_out;
        if (mode == `FJS_MODE_OCTET)
          gap_res <= gsum[2:0];
      end
    end
  end

endmodule
`default_nettype wire

// *** fjs_justifier_properties.sv ***
// Concurrent checks on the slot stream and register bus of the justifier.
`timescale 1ns/1ps
`default_nettype none
module fjs_justifier_properties (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic SLOT_REQ,
  input wire logic SLOT_VALID,
  input wire logic SLOT_IDLE,
  input wire logic SLOT_PSM,
  input wire logic [63:0] SLOT_DATA,
  input wire logic [15:0] FRAME_USED,
  input wire logic [7:0] FRAME_GAP,
  input wire logic POS_JUSTIFY_EVENT,
  input wire logic NEG_JUSTIFY_EVENT,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  a_slot_answer: assert property (SLOT_REQ |=> SLOT_VALID) else $error("slot late");
  a_slot_quiet: assert property (!SLOT_REQ |=> !SLOT_VALID) else $error("slot extra");
  a_event_slot: assert property ((POS_JUSTIFY_EVENT || NEG_JUSTIFY_EVENT) |-> SLOT_VALID)
    else $error("event off slot");
  a_event_excl: assert property (POS_JUSTIFY_EVENT |-> !NEG_JUSTIFY_EVENT)
    else $error("both events");
  a_idle_empty: assert property (SLOT_VALID && SLOT_IDLE |-> SLOT_DATA == 64'h0)
    else $error("idle carries data");
  a_psm_idle: assert property (SLOT_PSM |-> SLOT_IDLE) else $error("marker not idle");
  a_used_no_idle: assert property (FRAME_USED != 16'h0 |-> !SLOT_IDLE)
    else $error("idle in frame mode");
  a_gap_no_idle: assert property (FRAME_GAP != 8'h0 |-> !SLOT_IDLE)
    else $error("gap in slot mode");
  a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
  a_bvalid_clears: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_rvalid_clears: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  c_pos: cover property (POS_JUSTIFY_EVENT);
  c_neg: cover property (NEG_JUSTIFY_EVENT);
  c_psm: cover property (SLOT_PSM);
  c_gap: cover property (FRAME_GAP != 8'h0);
endmodule
bind fjs_justifier fjs_justifier_properties u_props (.*);
`default_nettype wire

// *** fjs_slot_sink.sv ***
// Far-side slot consumer that paces slot requests and counts idle words.
`timescale 1ns/1ps
`default_nettype none
module fjs_slot_sink (
  input wire logic clk,
  input wire logic nrst,
  input wire logic want,
  input wire logic want_psm,
  input wire logic slot_valid,
  input wire logic slot_idle,
  output logic slot_req,
  output logic psm_req,
  output logic [15:0] idle_seen
);
  // Requests are registered, so the far side asks one cycle after it decides.
  always @(posedge clk) begin
    if (!nrst) begin
      slot_req <= 1'b0;
      psm_req <= 1'b0;
      idle_seen <= 16'h0;
    end else begin
      slot_req <= want;
      psm_req <= want_psm;
      // Idle words are only counted here and never added to the channel.
      if (slot_valid && slot_idle) idle_seen <= idle_seen + 16'h1;
    end
  end
endmodule
`default_nettype wire

// *** fjs_justifier_tb_top.sv ***
// Self-checking bench for the frequency justifier and its slot consumer.
`timescale 1ns/1ps
`default_nettype none
`include "fjs_regs.vh"
module fjs_justifier_tb_top;
  localparam logic [63:0] W = 64'h0123456789abcdef;
  localparam logic [31:0] M = 32'hffffffff;
  logic CLK_SYS, NRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_RREADY, CLI_VALID, SLOT_REQ, PSM_REQ, want, want_psm;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic CLI_READY, SLOT_VALID, SLOT_IDLE, SLOT_PSM, POS_JUSTIFY_EVENT, NEG_JUSTIFY_EVENT;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, FRAME_GAP;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [63:0] CLI_DATA, SLOT_DATA;
  logic [6:0] CLI_BITS;
  logic [15:0] FRAME_USED, idle_seen;
  int errors, samples_checked, pe, ne;
  fjs_justifier dut (.*);
  fjs_slot_sink sink (.clk(CLK_SYS), .nrst(NRST), .want(want), .want_psm(want_psm),
    .slot_valid(SLOT_VALID), .slot_idle(SLOT_IDLE), .slot_req(SLOT_REQ), .psm_req(PSM_REQ),
    .idle_seen(idle_seen));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rst();
    @(posedge CLK_SYS) NRST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1'b1;
    pe = 0;
    ne = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk("bresp", er, S_AXI_BRESP);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk("rdata", e, S_AXI_RDATA & m);
    chk("rresp", er, S_AXI_RRESP);
  endtask
  task automatic push(input int n);
    @(posedge CLK_SYS) CLI_VALID <= 1'b1;
    repeat (n) @(posedge CLK_SYS);
    CLI_VALID <= 1'b0;
  endtask
  // Outputs are judged just after the edge at which the justifier takes the request.
  task automatic slot(input logic p);
    @(posedge CLK_SYS) want <= 1'b1;
    want_psm <= p;
    @(posedge CLK_SYS) want <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    chk("slot_valid", 1'b1, SLOT_VALID);
    pe += POS_JUSTIFY_EVENT;
    ne += NEG_JUSTIFY_EVENT;
  endtask
  task automatic setup(input logic [31:0] c, input int n);
    rst();
    wr(`FJS_OFF_CTRL, c, `FJS_RESP_OKAY);
    push(n);
  endtask
  task automatic t_regs();
    rst();
    chk("cli_ready", 1'b1, CLI_READY);
    rd(`FJS_OFF_NOM, `FJS_RST_NOM, M, `FJS_RESP_OKAY);
    rd(`FJS_OFF_STEP, `FJS_RST_STEP, M, `FJS_RESP_OKAY);
    rd(`FJS_OFF_THR_HI, `FJS_RST_THR_HI, M, `FJS_RESP_OKAY);
    rd(`FJS_OFF_THR_LO, `FJS_RST_THR_LO, M, `FJS_RESP_OKAY);
    rd(`FJS_OFF_OPP, `FJS_RST_OPP, M, `FJS_RESP_OKAY);
    rd(8'h30, 32'h0, M, `FJS_RESP_SLVERR);
    wr(`FJS_OFF_STATUS, 32'h1, `FJS_RESP_SLVERR);
    wr(8'h30, 32'h1, `FJS_RESP_SLVERR);
  endtask
  task automatic t_async();
    rst();
    slot(1'b1);
    chk("idle", 1'b1, SLOT_IDLE);
    chk("psm", 1'b1, SLOT_PSM);
    push(1);
    slot(1'b0);
    chk("data", W, SLOT_DATA);
    chk("events", 0, pe + ne);
    chk("idles", 16'h1, idle_seen);
  endtask
  task automatic t_slot();
    setup(32'h15, 8);
    slot(1'b0);
    slot(1'b0);
    chk("pos", 1, pe);
    chk("data", W, SLOT_DATA);
    rd(`FJS_OFF_STATUS, 32'h180, 32'hffff, `FJS_RESP_OKAY);
    rd(`FJS_OFF_POS_CNT, 32'h1, M, `FJS_RESP_OKAY);
    wr(`FJS_OFF_POS_CNT, 32'h0, `FJS_RESP_OKAY);
    rd(`FJS_OFF_POS_CNT, 32'h0, M, `FJS_RESP_OKAY);
    setup(32'h15, 1);
    slot(1'b0);
    slot(1'b0);
    chk("neg", 1, ne);
    chk("idle", 1'b1, SLOT_IDLE);
    rd(`FJS_OFF_NEG_CNT, 32'h1, M, `FJS_RESP_OKAY);
    setup(32'h1d, 4);
    repeat (4) slot(1'b0);
    chk("dither", 4, pe + ne);
    rd(`FJS_OFF_POS_CNT, 32'h0, M, `FJS_RESP_OKAY);
    rd(`FJS_OFF_NEG_CNT, 32'h0, M, `FJS_RESP_OKAY);
  endtask
  task automatic t_frame();
    setup(32'h16, 8);
    wr(`FJS_OFF_GAP, 32'h4, `FJS_RESP_OKAY);
    slot(1'b0);
    chk("used", 16'd9, FRAME_USED);
    chk("gap", 8'd3, FRAME_GAP);
    rd(`FJS_OFF_STATUS, 32'd440, 32'hffff, `FJS_RESP_OKAY);
    setup(32'h16, 1);
    slot(1'b0);
    chk("used", 16'd7, FRAME_USED);
    setup(32'h17, 8);
    slot(1'b0);
    chk("used", 16'd9, FRAME_USED);
    rd(`FJS_OFF_STATUS, 32'd503, 32'hffff, `FJS_RESP_OKAY);
    setup(32'h17, 1);
    slot(1'b0);
    chk("used", 16'd7, FRAME_USED);
    // The consumer counts an idle word one edge after the slot appears.
    @(posedge CLK_SYS);
    #1;
    chk("idles", 16'h0, idle_seen);
    setup(32'h1e, 4);
    slot(1'b0);
    chk("dither_used", 16'd7, FRAME_USED);
    chk("dither_neg", 1, ne);
    rd(`FJS_OFF_NEG_CNT, 32'h0, M, `FJS_RESP_OKAY);
    setup(32'h13, 8);
    wr(`FJS_OFF_OPP, 32'h2, `FJS_RESP_OKAY);
    repeat (3) slot(1'b0);
    chk("opp", 1, pe);
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    {NRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = '0;
    {S_AXI_RREADY, CLI_VALID, want, want_psm, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    CLI_DATA = W;
    CLI_BITS = 7'h40;
    t_regs();
    t_async();
    t_slot();
    t_frame();
    report_and_stop();
  end
endmodule
`default_nettype wire
